// ===== sppm_pkg.sv
package sppm_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_PORTS = 8;
  localparam int NUM_DS = NUM_PORTS - 1;
  localparam int TO_W = 16;
  localparam int TICK_W = 16;
  localparam logic [TICK_W-1:0] TICK_CYCLES = 16'h00C8;

  // ****************************************
  // Power state field encodings
  // ****************************************
  localparam logic [1:0] PSF_D0 = 2'h0;
  localparam logic [1:0] PSF_D3HOT = 2'h3;
  localparam logic CONTEXT_KEPT_RESET = 1'h1;

  // ****************************************
  // Bridge power states
  // ****************************************
  typedef enum logic [1:0] {
    DS_D0_UNINIT = 2'h0,
    DS_D0_ACTIVE = 2'h1,
    DS_D3_HOT = 2'h3,
    DS_D3_COLD = 2'h2
  } sppm_dstate_t;

  // ****************************************
  // Turn-off aggregation states
  // ****************************************
  typedef enum logic [1:0] {
    AG_IDLE = 2'h0,
    AG_COLLECT = 2'h1,
    AG_SCHED = 2'h3,
    AG_DONE = 2'h2
  } sppm_agg_t;

  // ****************************************
  // TLP dispositions
  // ****************************************
  localparam logic [1:0] DISP_NORMAL = 2'h0;
  localparam logic [1:0] DISP_UR = 2'h1;
  localparam logic [1:0] DISP_UC = 2'h2;
  localparam logic [1:0] DISP_ROUTE = 2'h3;

endpackage : sppm_pkg

// ===== sppm_port.sv
`timescale 1ns/1ps
module sppm_port
  import sppm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic is_downstream,
  input wire logic pme_capable,
  input wire logic psf_wr,
  input wire logic [1:0] psf_wdata,
  input wire logic configured,
  input wire logic power_removed,
  input wire logic wake_req,
  input wire logic wake_status_clr,
  input wire logic [TO_W-1:0] wake_to,
  input wire logic turnoff_fwd,
  input wire logic ack_rx,
  input wire logic [TO_W-1:0] ack_to,
  output sppm_dstate_t dstate,
  output logic wake_status,
  output logic wake_send,
  output logic ack_done,
  output logic ack_timeout
);
  // ****************************************
  // Device power state
  // ****************************************
  sppm_dstate_t next_dstate;
  always_comb begin
    next_dstate = dstate;
    case (dstate)
      DS_D0_UNINIT: if (configured) next_dstate = DS_D0_ACTIVE;
      DS_D0_ACTIVE: if (psf_wr && psf_wdata == PSF_D3HOT) next_dstate = DS_D3_HOT;
      DS_D3_HOT: begin
        if (power_removed) next_dstate = DS_D3_COLD;
        else if (psf_wr && psf_wdata == PSF_D0) next_dstate = DS_D0_UNINIT;
      end
      DS_D3_COLD: next_dstate = DS_D3_COLD;
      default: next_dstate = DS_D0_UNINIT;
    endcase
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) dstate <= DS_D0_UNINIT;
    else dstate <= next_dstate;
  end

  // ****************************************
  // Wake message service timer
  // ****************************************
  logic [TO_W-1:0] wake_cnt;
  logic wake_ok;
  assign wake_ok = is_downstream && pme_capable && dstate == DS_D3_HOT && !power_removed;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wake_status <= 1'h0;
      wake_send <= 1'h0;
      wake_cnt <= '0;
    end else begin
      wake_send <= 1'h0;
      if (wake_ok && wake_req && !wake_status) begin
        wake_status <= 1'h1;
        wake_send <= 1'h1;
        wake_cnt <= wake_to;
      end else if (wake_status && wake_status_clr && !(wake_ok && wake_req)) begin
        wake_status <= 1'h0;
      end else if (wake_status && wake_ok && tick) begin
        if (wake_cnt == '0) begin
          wake_send <= 1'h1;
          wake_cnt <= wake_to;
        end else begin
          wake_cnt <= wake_cnt - 1'h1;
        end
      end
    end
  end

  // ****************************************
  // Turn-off acknowledge timer
  // ****************************************
  logic ack_wait;
  logic [TO_W-1:0] ack_cnt;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_wait <= 1'h0;
      ack_done <= 1'h0;
      ack_timeout <= 1'h0;
      ack_cnt <= '0;
    end else if (turnoff_fwd) begin
      ack_wait <= 1'h1;
      ack_done <= 1'h0;
      ack_timeout <= 1'h0;
      ack_cnt <= ack_to;
    end else if (ack_wait) begin
      if (ack_rx) begin
        ack_wait <= 1'h0;
        ack_done <= 1'h1;
      end else if (tick) begin
        if (ack_cnt == '0) begin
          ack_wait <= 1'h0;
          ack_done <= 1'h1;
          ack_timeout <= 1'h1;
        end else begin
          ack_cnt <= ack_cnt - 1'h1;
        end
      end
    end
  end
endmodule : sppm_port

// ===== sppm_top.sv
// Function
// - Each downstream bridge power state affects only its own port.
// - Port in D3hot requests link L1 regardless of other ports.
// - Upstream low power plus all acks puts whole switch low power.
// - States D0 uninit, D0 active, D3hot, D3cold; reset to D0 uninit.
// - D3hot on power state write; D3cold only on power removal.
// - D0 write from D3hot returns to D0 uninit, context kept.
// - In D3hot, type 0 config and own messages still served.
// - In D3hot, other primary-side requests are unsupported.
// - In D3hot, TLP-caused errors reported; other errors dropped.
// - In D3hot, own completions unexpected; passing completions routed.
// - In D3hot, secondary-side requests are unsupported.
// - No wake messages from D3cold; downstream ports send from D3hot.
// - Resend wake message when status not cleared before time-out.
// - Turn-off from upstream forwarded on all active downstream ports.
// - Ack upstream and L2/L3 ready only after all downstream acks.
// - TLP before ack scheduled abandons collection; later TLPs droppable.
// - Abandoning TLP handled, forwarded, or link retrained then forwarded.
// - Abandonment leaves downstream turn-off exchanges running.
// - No downstream ack before time-out counts as ack, link L2/L3 ready.
// - Return to D0 uninit stops wake messages.
`timescale 1ns/1ps
module sppm_top
  import sppm_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Power state control, per port (0 is upstream)
  input wire logic [sppm_pkg::NUM_PORTS-1:0] PSF_WR,
  input wire logic [2*sppm_pkg::NUM_PORTS-1:0] PSF_WDATA,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] CONFIGURED,
  input wire logic POWER_REMOVED,
  output logic [2*sppm_pkg::NUM_PORTS-1:0] PORT_DSTATE,
  output logic [sppm_pkg::NUM_PORTS-1:0] CONTEXT_KEPT_FLAG,
  output logic [sppm_pkg::NUM_PORTS-1:0] LINK_L1_REQ,
  output logic DEVICE_LOW_POWER,
  // Wake messages, per port
  input wire logic [sppm_pkg::NUM_PORTS-1:0] PME_CAPABLE,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] WAKE_REQ,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] WAKE_STATUS_CLR,
  input wire logic [sppm_pkg::TO_W*sppm_pkg::NUM_PORTS-1:0] WAKE_MSG_TIMEOUT_VALUE,
  output logic [sppm_pkg::NUM_PORTS-1:0] WAKE_EVENT_STATUS,
  output logic [sppm_pkg::NUM_PORTS-1:0] WAKE_MSG_SEND,
  // Incoming TLP classification
  input wire logic [sppm_pkg::NUM_PORTS-1:0] TLP_VALID,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] TLP_SECONDARY,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] TLP_IS_REQ,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] TLP_CFG0,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] TLP_MSG_SELF,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] TLP_CPL_SELF,
  output logic [2*sppm_pkg::NUM_PORTS-1:0] TLP_DISP,
  // Error message gating
  input wire logic [sppm_pkg::NUM_PORTS-1:0] ERR_REQ,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] ERR_FROM_TLP,
  output logic [sppm_pkg::NUM_PORTS-1:0] ERR_SEND,
  // Turn-off and acknowledge
  input wire logic TURNOFF_RX,
  input wire logic UP_TLP_RX,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] PORT_ACTIVE,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] ACK_RX,
  input wire logic [sppm_pkg::TO_W*sppm_pkg::NUM_PORTS-1:0] TURNOFF_ACK_TIMEOUT_VALUE,
  output logic [sppm_pkg::NUM_PORTS-1:0] TURNOFF_FWD,
  output logic [sppm_pkg::NUM_PORTS-1:0] ACK_TIMEOUT,
  output logic [sppm_pkg::NUM_PORTS-1:0] LINK_L23_REQ,
  output logic ACK_UP_SEND,
  output logic AGG_ABANDONED,
  output logic UP_TLP_DROP,
  // Retrain for abandoning TLP
  input wire logic [sppm_pkg::NUM_PORTS-1:0] PORT_IN_L0,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] TLP_TARGET,
  output logic [sppm_pkg::NUM_PORTS-1:0] RETRAIN_REQ,
  output logic [sppm_pkg::NUM_PORTS-1:0] TLP_FWD
);
  import sppm_pkg::*;

  // ****************************************
  // Time unit tick
  // ****************************************
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  assign tick = tick_cnt == '0;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) tick_cnt <= '0;
    else if (tick) tick_cnt <= TICK_CYCLES - 1'h1;
    else tick_cnt <= tick_cnt - 1'h1;
  end

  // ****************************************
  // Per-port power logic
  // ****************************************
  sppm_dstate_t dst [NUM_PORTS];
  logic [NUM_PORTS-1:0] d3hot;
  logic [NUM_PORTS-1:0] ack_done;
  logic [NUM_PORTS-1:0] fwd;
  logic [NUM_PORTS-1:0] pend;
  logic [NUM_PORTS-1:0] disp_hi;
  logic [NUM_PORTS-1:0] disp_lo;
  sppm_agg_t agg;
  logic whole_d3;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      sppm_port u_port (
        .clock(CLOCK),
        .sys_rst(SYS_RST),
        .tick(tick),
        .is_downstream(g != 0),
        .pme_capable(PME_CAPABLE[g]),
        .psf_wr(PSF_WR[g]),
        .psf_wdata(PSF_WDATA[2*g +: 2]),
        .configured(CONFIGURED[g]),
        .power_removed(POWER_REMOVED),
        .wake_req(WAKE_REQ[g]),
        .wake_status_clr(WAKE_STATUS_CLR[g]),
        .wake_to(WAKE_MSG_TIMEOUT_VALUE[TO_W*g +: TO_W]),
        .turnoff_fwd(fwd[g]),
        .ack_rx(ACK_RX[g]),
        .ack_to(TURNOFF_ACK_TIMEOUT_VALUE[TO_W*g +: TO_W]),
        .dstate(dst[g]),
        .wake_status(WAKE_EVENT_STATUS[g]),
        .wake_send(WAKE_MSG_SEND[g]),
        .ack_done(ack_done[g]),
        .ack_timeout(ACK_TIMEOUT[g])
      );
      assign PORT_DSTATE[2*g +: 2] = dst[g];
      assign d3hot[g] = dst[g] == DS_D3_HOT;
      assign CONTEXT_KEPT_FLAG[g] = CONTEXT_KEPT_RESET;
      assign LINK_L1_REQ[g] = d3hot[g];
      assign fwd[g] = (g != 0) && TURNOFF_RX && PORT_ACTIVE[g];
      assign TURNOFF_FWD[g] = fwd[g];
      assign pend[g] = (g != 0) && PORT_ACTIVE[g] && !ack_done[g];

      // TLP disposition in D3hot
      always_comb begin
        disp_hi[g] = 1'h0;
        disp_lo[g] = 1'h0;
        if (d3hot[g] || whole_d3) begin
          if (!TLP_IS_REQ[g]) begin
            {disp_hi[g], disp_lo[g]} = TLP_CPL_SELF[g] ? DISP_UC : DISP_ROUTE;
          end else if (TLP_SECONDARY[g]) begin
            {disp_hi[g], disp_lo[g]} = DISP_UR;
          end else if (TLP_CFG0[g] || TLP_MSG_SELF[g]) begin
            {disp_hi[g], disp_lo[g]} = DISP_NORMAL;
          end else begin
            {disp_hi[g], disp_lo[g]} = DISP_UR;
          end
        end else if (!TLP_IS_REQ[g] && !TLP_CPL_SELF[g]) begin
          {disp_hi[g], disp_lo[g]} = DISP_ROUTE;
        end
      end
    end
  endgenerate

  // ****************************************
  // Registered TLP disposition and errors
  // ****************************************
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TLP_DISP <= '0;
      ERR_SEND <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        TLP_DISP[2*i +: 2] <= TLP_VALID[i] ? {disp_hi[i], disp_lo[i]} : DISP_NORMAL;
        ERR_SEND[i] <= ERR_REQ[i] && (!(d3hot[i] || whole_d3) || ERR_FROM_TLP[i]);
      end
    end
  end

  // ****************************************
  // Turn-off acknowledge aggregation
  // ****************************************
  sppm_agg_t next_agg;
  always_comb begin
    next_agg = agg;
    case (agg)
      AG_IDLE: if (TURNOFF_RX) next_agg = AG_COLLECT;
      AG_COLLECT: begin
        if (UP_TLP_RX) next_agg = AG_IDLE;
        else if (pend == '0) next_agg = AG_SCHED;
      end
      AG_SCHED: next_agg = AG_DONE;
      AG_DONE: if (TURNOFF_RX) next_agg = AG_COLLECT;
      default: next_agg = AG_IDLE;
    endcase
  end
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) agg <= AG_IDLE;
    else agg <= next_agg;
  end
  assign ACK_UP_SEND = agg == AG_SCHED;
  assign UP_TLP_DROP = UP_TLP_RX && (agg == AG_SCHED || agg == AG_DONE);
  assign whole_d3 = dst[0] == DS_D3_HOT;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      AGG_ABANDONED <= 1'h0;
      DEVICE_LOW_POWER <= 1'h0;
    end else begin
      if (agg == AG_COLLECT && UP_TLP_RX) AGG_ABANDONED <= 1'h1;
      else if (TURNOFF_RX) AGG_ABANDONED <= 1'h0;
      DEVICE_LOW_POWER <= (dst[0] == DS_D3_HOT || dst[0] == DS_D3_COLD) && agg == AG_DONE;
    end
  end

  // ****************************************
  // Link L2/L3 ready and retrain
  // ****************************************
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LINK_L23_REQ <= '0;
      RETRAIN_REQ <= '0;
      TLP_FWD <= '0;
    end else begin
      LINK_L23_REQ[0] <= agg == AG_SCHED || (LINK_L23_REQ[0] && !TURNOFF_RX && !UP_TLP_RX);
      RETRAIN_REQ[0] <= 1'h0;
      TLP_FWD[0] <= 1'h0;
      for (int i = 1; i < NUM_PORTS; i++) begin
        if (fwd[i]) LINK_L23_REQ[i] <= 1'h0;
        else if (ack_done[i]) LINK_L23_REQ[i] <= 1'h1;
        if (TLP_TARGET[i] && !PORT_IN_L0[i]) RETRAIN_REQ[i] <= 1'h1;
        else if (PORT_IN_L0[i]) RETRAIN_REQ[i] <= 1'h0;
        TLP_FWD[i] <= TLP_TARGET[i] && PORT_IN_L0[i];
      end
    end
  end
endmodule : sppm_top

// ===== sppm_asserts.sv
`timescale 1ns/1ps
module sppm_asserts
  import sppm_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Watched ports
  input wire logic [sppm_pkg::NUM_PORTS-1:0] PSF_WR,
  input wire logic [2*sppm_pkg::NUM_PORTS-1:0] PSF_WDATA,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] CONFIGURED,
  input wire logic POWER_REMOVED,
  input wire logic [2*sppm_pkg::NUM_PORTS-1:0] PORT_DSTATE,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] LINK_L1_REQ,
  input wire logic DEVICE_LOW_POWER,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] WAKE_EVENT_STATUS,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] WAKE_MSG_SEND,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] ERR_REQ,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] ERR_FROM_TLP,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] ERR_SEND,
  input wire logic TURNOFF_RX,
  input wire logic ACK_UP_SEND,
  input wire logic AGG_ABANDONED,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] LINK_L23_REQ
);
  import sppm_pkg::*;
  // ****************
  // Decoded states
  // ****************
  logic [NUM_PORTS-1:0] hot;
  logic [NUM_PORTS-1:0] cold;
  logic [NUM_PORTS-1:0] drop;
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      hot[i] = PORT_DSTATE[2*i+:2] == DS_D3_HOT;
      cold[i] = PORT_DSTATE[2*i+:2] == DS_D3_COLD;
    end
  end
  assign drop = ERR_REQ & ~ERR_FROM_TLP & hot;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  sequence up_ready_s;
    ##1 LINK_L23_REQ[0];
  endsequence
  l1_req_a: assert property (LINK_L1_REQ == hot) else $error("L1 request mismatch");
  cold_wake_a: assert property ((WAKE_MSG_SEND & cold) == '0) else $error("wake from D3cold");
  wake_stat_a: assert property ((WAKE_MSG_SEND & ~WAKE_EVENT_STATUS) == '0) else $error("send without status");
  up_l23_a: assert property (ACK_UP_SEND |-> up_ready_s) else $error("no L2/L3 after ack");
  ack_abandon_a: assert property (AGG_ABANDONED && !TURNOFF_RX |=> !ACK_UP_SEND) else $error("ack after abandon");
  low_pwr_a: assert property (DEVICE_LOW_POWER |-> $past(PORT_DSTATE[1])) else $error("low power while up");
  err_drop_a: assert property (|drop |=> (ERR_SEND & $past(drop)) == '0) else $error("error not dropped");
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    cfg_act_a: assert property (PORT_DSTATE[2*i+:2] == DS_D0_UNINIT && CONFIGURED[i] && !PSF_WR[i]
      |=> PORT_DSTATE[2*i+:2] == DS_D0_ACTIVE) else $error("configure ignored");
    d3_in_a: assert property (PORT_DSTATE[2*i+:2] == DS_D0_ACTIVE && PSF_WR[i] && !POWER_REMOVED
      && PSF_WDATA[2*i+:2] == PSF_D3HOT |=> PORT_DSTATE[2*i+:2] == DS_D3_HOT) else $error("no D3hot entry");
    d0_back_a: assert property (PORT_DSTATE[2*i+:2] == DS_D3_HOT && PSF_WR[i] && !POWER_REMOVED
      && PSF_WDATA[2*i+:2] == PSF_D0 |=> PORT_DSTATE[2*i+:2] == DS_D0_UNINIT) else $error("no D0 return");
  end
endmodule : sppm_asserts

bind sppm_top sppm_asserts sppm_asserts_inst (.CLOCK, .SYS_RST, .PSF_WR, .PSF_WDATA, .CONFIGURED, .POWER_REMOVED,
  .PORT_DSTATE, .LINK_L1_REQ, .DEVICE_LOW_POWER, .WAKE_EVENT_STATUS, .WAKE_MSG_SEND, .ERR_REQ, .ERR_FROM_TLP,
  .ERR_SEND, .TURNOFF_RX, .ACK_UP_SEND, .AGG_ABANDONED, .LINK_L23_REQ);

// ===== sppm_partner.sv
`timescale 1ns/1ps
module sppm_partner
  import sppm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Turn-off broadcast and answer style
  input wire logic turnoff,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] active,
  input wire logic [sppm_pkg::NUM_PORTS-1:0] silent,
  input wire logic [7:0] delay,
  // Acknowledge per downstream port
  output logic [sppm_pkg::NUM_PORTS-1:0] ack_rx
);
  import sppm_pkg::*;
  logic [7:0] wait_cnt [NUM_PORTS];
  logic [NUM_PORTS-1:0] pending;
  // Each device answers after its own delay, never when silent
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= '0;
      ack_rx <= '0;
    end else begin
      for (int i = 1; i < NUM_PORTS; i++) begin
        ack_rx[i] <= pending[i] && wait_cnt[i] == 8'h00;
        if (turnoff) begin
          pending[i] <= active[i] && !silent[i];
          wait_cnt[i] <= delay + 8'(i);
        end else if (pending[i]) begin
          pending[i] <= wait_cnt[i] != 8'h00;
          wait_cnt[i] <= wait_cnt[i] - 8'h01;
        end
      end
    end
  end
endmodule : sppm_partner

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import sppm_pkg::*;
  // ****************
  // Signals
  // ****************
  logic clock = 1'h0, sys_rst = 1'h1, power_removed = 1'h0, turnoff_rx = 1'h0, up_tlp_rx = 1'h0;
  logic [NUM_PORTS-1:0] psf_wr = '0, configured = '0, pme_capable = '1, wake_req = '0, wake_clr = '0;
  logic [NUM_PORTS-1:0] tlp_valid = '0, tlp_sec = '0, tlp_req = '0, tlp_cfg0 = '0, tlp_cpl = '0, tlp_msg = '0;
  logic [NUM_PORTS-1:0] err_req = '0, err_tlp = '0, port_active = 8'hFE, silent = '0;
  logic [NUM_PORTS-1:0] in_l0 = 8'hFF, tlp_target = '0;
  logic [2*NUM_PORTS-1:0] psf_wdata = '0;
  logic [2*NUM_PORTS-1:0] dstate, disp;
  logic [NUM_PORTS-1:0] ack_rx, ctx, l1_req, wake_stat, wake_send, err_send, ack_tout, l23_req;
  logic [NUM_PORTS-1:0] fwd_out, retrain, tlp_fwd;
  logic low_pwr, ack_up, abandoned, seen7, up_drop;
  int mismatches = 0, comparisons = 0, cnt, waited;
  always #2.5 clock = ~clock;
  sppm_top sppm_top_inst (
    .CLOCK(clock), .SYS_RST(sys_rst), .PSF_WR(psf_wr), .PSF_WDATA(psf_wdata), .CONFIGURED(configured),
    .POWER_REMOVED(power_removed), .PORT_DSTATE(dstate), .CONTEXT_KEPT_FLAG(ctx), .LINK_L1_REQ(l1_req),
    .DEVICE_LOW_POWER(low_pwr), .PME_CAPABLE(pme_capable), .WAKE_REQ(wake_req), .WAKE_STATUS_CLR(wake_clr),
    .WAKE_MSG_TIMEOUT_VALUE({NUM_PORTS{16'h0000}}), .WAKE_EVENT_STATUS(wake_stat), .WAKE_MSG_SEND(wake_send),
    .TLP_VALID(tlp_valid), .TLP_SECONDARY(tlp_sec), .TLP_IS_REQ(tlp_req), .TLP_CFG0(tlp_cfg0),
    .TLP_MSG_SELF(tlp_msg), .TLP_CPL_SELF(tlp_cpl), .TLP_DISP(disp), .ERR_REQ(err_req), .ERR_FROM_TLP(err_tlp),
    .ERR_SEND(err_send), .TURNOFF_RX(turnoff_rx), .UP_TLP_RX(up_tlp_rx), .PORT_ACTIVE(port_active),
    .ACK_RX(ack_rx), .TURNOFF_ACK_TIMEOUT_VALUE({NUM_PORTS{16'h0002}}), .TURNOFF_FWD(fwd_out),
    .ACK_TIMEOUT(ack_tout), .LINK_L23_REQ(l23_req), .ACK_UP_SEND(ack_up), .AGG_ABANDONED(abandoned),
    .UP_TLP_DROP(up_drop), .PORT_IN_L0(in_l0), .TLP_TARGET(tlp_target), .RETRAIN_REQ(retrain),
    .TLP_FWD(tlp_fwd));
  sppm_partner sppm_partner_inst (.clock(clock), .sys_rst(sys_rst), .turnoff(turnoff_rx),
    .active(port_active), .silent(silent), .delay(8'h03), .ack_rx(ack_rx));
  // ****************
  // Tasks
  // ****************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic psf(input logic [7:0] mask, input logic [1:0] val);
    psf_wr = mask;
    psf_wdata = {NUM_PORTS{val}};
    tick(1);
    psf_wr = '0;
    tick(1);
  endtask : psf
  task automatic tlp(input logic [3:0] kind, input logic [1:0] exp);
    tlp_valid = 8'h02;
    {tlp_sec, tlp_req, tlp_cfg0, tlp_cpl} = {{8{kind[3]}}, {8{kind[2]}}, {8{kind[1]}}, {8{kind[0]}}};
    tick(1);
    check("tlp_disp", disp[3:2], exp);
    tlp_valid = '0;
    tick(1);
  endtask : tlp
  task automatic err(input logic from_tlp, input logic [7:0] exp);
    err_req = 8'h02;
    err_tlp = {NUM_PORTS{from_tlp}};
    tick(1);
    check("err_send", err_send, exp);
    err_req = '0;
    tick(1);
  endtask : err
  task automatic wake(input logic [7:0] exp);
    wake_req = 8'h06;
    tick(1);
    check("wake_send", wake_send, exp);
    wake_req = '0;
    tick(1);
  endtask : wake
  task automatic count_wake(input int n);
    cnt = 0;
    repeat (n) begin
      tick(1);
      if (wake_send[1] === 1'b1) cnt++;
    end
  endtask : count_wake
  task automatic turnoff(input logic abandon, input int limit);
    seen7 = 1'b0;
    waited = 0;
    turnoff_rx = 1'b1;
    tick(1);
    check("turnoff_fwd", fwd_out, 8'hFE);
    turnoff_rx = 1'b0;
    up_tlp_rx = abandon;
    tick(1);
    up_tlp_rx = 1'b0;
    while (ack_up !== 1'b1 && waited < limit) begin
      if (ack_rx[7] === 1'b1) seen7 = 1'b1;
      tick(1);
      waited++;
    end
  endtask : turnoff
  task automatic print_verdict;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // ****************
  // Sequence
  // ****************
  initial begin
    #100000;
    mismatches++;
    print_verdict;
  end
  initial begin
    tick(6);
    sys_rst = 1'b0;
    tick(1);
    check("dstate", dstate, 16'h0000);
    check("ctx", ctx, 8'hFF);
    configured = '1;
    tick(1);
    configured = '0;
    tick(1);
    check("dstate", dstate, 16'h5555);
    psf(8'h02, PSF_D3HOT);
    check("dstate", dstate, 16'h555D);
    check("l1_req", l1_req, 8'h02);
    psf(8'h04, PSF_D0);
    check("dstate", dstate, 16'h555D);
    tlp(4'b0110, DISP_NORMAL);
    tlp_msg = 8'h02;
    tlp(4'b0100, DISP_NORMAL);
    tlp_msg = '0;
    tlp(4'b0100, DISP_UR);
    tlp(4'b1100, DISP_UR);
    tlp(4'b0001, DISP_UC);
    tlp(4'b0000, DISP_ROUTE);
    err(1'b1, 8'h02);
    err(1'b0, 8'h00);
    wake(8'h02);
    check("wake_stat", wake_stat, 8'h02);
    count_wake(450);
    check("resend", cnt >= 2, 1'b1);
    wake_clr = 8'h02;
    tick(1);
    wake_clr = '0;
    count_wake(450);
    check("resend", cnt, 0);
    psf(8'h02, PSF_D0);
    check("dstate", dstate, 16'h5551);
    configured = 8'h02;
    tick(1);
    configured = '0;
    tick(1);
    psf(8'h02, PSF_D3HOT);
    wake(8'h02);
    psf(8'hFF, PSF_D3HOT);
    check("dstate", dstate, 16'hFFFF);
    turnoff(1'b1, 100);
    check("abandoned", abandoned, 1'b1);
    check("ack_wait", waited, 100);
    check("l23", l23_req, 8'hFE);
    turnoff(1'b0, 100);
    check("order", seen7, 1'b1);
    tick(1);
    check("l23_up", l23_req[0], 1'b1);
    tick(1);
    check("low_pwr", low_pwr, 1'b1);
    up_tlp_rx = 1'b1;
    tick(1);
    check("drop", up_drop, 1'b1);
    up_tlp_rx = 1'b0;
    tlp_target = 8'h04;
    in_l0 = 8'hFB;
    tick(1);
    check("retrain", retrain, 8'h04);
    check("tlp_fwd", tlp_fwd, 8'h00);
    in_l0 = 8'hFF;
    tick(1);
    check("retrain", retrain, 8'h00);
    check("tlp_fwd", tlp_fwd, 8'h04);
    tlp_target = '0;
    silent = 8'h80;
    turnoff(1'b0, 1000);
    check("ack_tout", ack_tout, 8'h80);
    check("ack_wait", waited < 1000, 1'b1);
    power_removed = 1'b1;
    tick(1);
    check("dstate", dstate, 16'hAAAA);
    wake(8'h00);
    print_verdict;
  end
endmodule : tb
